// file: pkg/ewp_consts.svh
// ewp_consts.svh: numeric constants shared by both ends of the three-wire
// programmable word port. assumes a 20 MHz reference clock on both ends.
`ifndef EWP_CONSTS_SVH
`define EWP_CONSTS_SVH

// array geometry
`define EWP_WORDS 64
`define EWP_ADDR_W 6
`define EWP_DATA_W 16
`define EWP_CMD_BITS 8

// fixed bit values on the wire
`define EWP_START_BIT 1'h1
`define EWP_DUMMY_BIT 1'h0
`define EWP_READY_BIT 1'h1
`define EWP_BUSY_BIT 1'h0
`define EWP_IDLE_LINE 1'h1
`define EWP_ERASED_WORD 16'hffff

// timing in ns, plus the reference clock period
`define EWP_CLK_NS 50
`define EWP_T_WP_NS 5000000
`define EWP_T_CS_NS 250
`define EWP_T_SHIFT_HIGH_NS 250

// cycles a level needs through a two-flop synchroniser and an output flop
`define EWP_SYNC_LAT 4

`endif

// file: pkg/ewp_pkg.sv
// ewp_pkg: types shared by the device end and the host end.
// assumes ewp_consts.svh supplies the numeric constants.
package ewp_pkg;

  // two-bit instruction code following the start bit
  typedef enum logic [1:0] {
    EWP_OP_EXT = 2'b00,
    EWP_OP_WRITE = 2'b01,
    EWP_OP_READ = 2'b10,
    EWP_OP_ERASE = 2'b11
  } ewp_op_t;

  // top two address bits select the variant of the extended code
  typedef enum logic [1:0] {
    EWP_EXT_DISABLE = 2'b00,
    EWP_EXT_WRITE_ALL = 2'b01,
    EWP_EXT_ERASE_ALL = 2'b10,
    EWP_EXT_ENABLE = 2'b11
  } ewp_ext_t;

  typedef enum logic [2:0] {
    EWP_D_OFF = 3'b000,
    EWP_D_START = 3'b001,
    EWP_D_CMD = 3'b010,
    EWP_D_DATA = 3'b011,
    EWP_D_READ = 3'b100,
    EWP_D_HOLD = 3'b101
  } ewp_dev_state_t;

  typedef enum logic [1:0] {
    EWP_H_IDLE = 2'b00,
    EWP_H_SHIFT = 2'b01,
    EWP_H_GAP = 2'b10,
    EWP_H_POLL = 2'b11
  } ewp_host_state_t;

endpackage : ewp_pkg

// file: pkg/ewp_if.sv
// ewp_if: the three-wire link between host and device.
// assumes the line is pulled high whenever the device leaves it undriven.
`timescale 1ns/1ns
`include "ewp_consts.svh"
interface ewp_if;
  logic chip_select;
  logic shift_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic serial_out_line;

  // resolved level of the shared output wire
  assign serial_out_line = serial_out_oe ? serial_out : `EWP_IDLE_LINE;

  modport host (
    output chip_select,
    output shift_clock,
    output serial_in,
    input serial_out_line
  );

  modport device (
    input chip_select,
    input shift_clock,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );
endinterface : ewp_if

// file: src/ewp_skid.sv
// ewp_skid: two-entry buffer with valid and ready on both sides.
// assumes one clock; all outputs come straight from flops.
`timescale 1ns/1ns
module ewp_skid #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] spare_data;
  logic push;
  logic pop;

  if (WIDTH < 1) begin : g_chk
    $error("ewp_skid: WIDTH must be at least 1");
  end

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // head feeds the consumer, spare catches a word while the head stalls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'h0;
      out_data <= '0;
      spare_data <= '0;
      in_ready <= 1'h1;
    end else if (pop) begin
      if (!in_ready) begin
        out_data <= spare_data;
        in_ready <= 1'h1;
      end else if (push) begin
        out_data <= in_data;
      end else begin
        out_valid <= 1'h0;
      end
    end else if (push) begin
      if (!out_valid) begin
        out_data <= in_data;
        out_valid <= 1'h1;
      end else begin
        spare_data <= in_data;
        in_ready <= 1'h0; // full: stall the producer
      end
    end
  end
endmodule : ewp_skid

// file: src/ewp_device.sv
// ewp_device: the memory end of the three-wire link, 64 words of 16 bits.
// assumes the link pins are asynchronous to ref_clk and change slowly
// enough that a two-flop synchroniser sees every shift clock phase.
`timescale 1ns/1ns
`include "ewp_consts.svh"
module ewp_device
  import ewp_pkg::*;
#(
  parameter int WORDS = `EWP_WORDS,
  parameter int ADDR_W = `EWP_ADDR_W,
  parameter int DATA_W = `EWP_DATA_W,
  parameter int PROG_CYCLES = `EWP_T_WP_NS / `EWP_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  ewp_if.device link,
  output logic prog_busy,
  output logic prog_enabled
);
  localparam int CS_CYC = (`EWP_T_CS_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS;
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [4:0] CMD_LAST = 5'(`EWP_CMD_BITS - 1);
  localparam logic [4:0] DATA_LAST = 5'(DATA_W - 1);
  localparam logic [3:0] CS_LOW_MIN = 4'(CS_CYC);

  if (WORDS != (1 << ADDR_W) || ADDR_W != `EWP_CMD_BITS - 2 || DATA_W != `EWP_DATA_W
      || PROG_CYCLES < 1 || CS_CYC > 15) begin : g_chk
    $error("ewp_device: geometry or timing parameters not supported");
  end

  logic cs_s1, cs_s2, cs_q;
  logic shift_s1, shift_s2, shift_q;
  logic si_s1, si_s2;
  logic shift_rise, cs_rise;
  ewp_dev_state_t state;
  logic [4:0] bit_cnt;
  logic [`EWP_CMD_BITS-2:0] cmd_sr;
  logic [`EWP_CMD_BITS-1:0] dec;
  ewp_op_t dec_op;
  ewp_ext_t dec_ext;
  logic [ADDR_W-1:0] dec_addr;
  logic [DATA_W-1:0] data_sr;
  logic [DATA_W-1:0] rd_sr;
  logic data_all;
  logic [ADDR_W-1:0] data_addr;
  logic cmd_done, data_done;
  logic start_prog;
  logic next_all;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_word;
  logic pend_all;
  logic [ADDR_W-1:0] pend_addr;
  logic [DATA_W-1:0] pend_word;
  logic [CNT_W-1:0] wp_cnt;
  logic commit;
  logic [3:0] cs_low_cnt;
  logic status_armed;
  logic read_drive;
  logic [DATA_W-1:0] mem [WORDS];

  // two flops on each pin before anything looks at it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_s1 <= 1'h0;
      cs_s2 <= 1'h0;
      cs_q <= 1'h0;
      shift_s1 <= 1'h0;
      shift_s2 <= 1'h0;
      shift_q <= 1'h0;
      si_s1 <= 1'h0;
      si_s2 <= 1'h0;
    end else begin
      cs_s1 <= link.chip_select;
      cs_s2 <= cs_s1;
      cs_q <= cs_s2;
      shift_s1 <= link.shift_clock;
      shift_s2 <= shift_s1;
      shift_q <= shift_s2;
      si_s1 <= link.serial_in;
      si_s2 <= si_s1;
    end
  end

  // only rises while selected count as shift edges
  assign shift_rise = shift_s2 && !shift_q && cs_s2;
  assign cs_rise = cs_s2 && !cs_q;

  // the bit arriving now completes the opcode and address
  assign dec = {cmd_sr, si_s2};
  assign dec_op = ewp_op_t'(dec[`EWP_CMD_BITS-1 -: 2]);
  assign dec_ext = ewp_ext_t'(dec[ADDR_W-1 -: 2]);
  assign dec_addr = dec[ADDR_W-1:0];
  assign cmd_done = shift_rise && state == EWP_D_CMD && bit_cnt == CMD_LAST;
  assign data_done = shift_rise && state == EWP_D_DATA && bit_cnt == DATA_LAST;

  // decide whether this edge launches a programming cycle, and with what
  always_comb begin
    start_prog = 1'h0;
    next_all = 1'h0;
    next_addr = dec_addr;
    next_word = `EWP_ERASED_WORD;
    if (cmd_done && prog_enabled) begin
      if (dec_op == EWP_OP_ERASE) begin
        start_prog = 1'h1;
      end else if (dec_op == EWP_OP_EXT && dec_ext == EWP_EXT_ERASE_ALL) begin
        start_prog = 1'h1;
        next_all = 1'h1;
      end
    end else if (data_done && prog_enabled) begin
      start_prog = 1'h1;
      next_all = data_all;
      next_addr = data_addr;
      next_word = {data_sr[DATA_W-2:0], si_s2};
    end
  end

  // frame decoder; a busy device ignores new frames until the cycle ends
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= EWP_D_OFF;
      bit_cnt <= 5'h0;
      cmd_sr <= '0;
      data_sr <= '0;
      data_all <= 1'h0;
      data_addr <= '0;
    end else if (!cs_s2) begin
      state <= EWP_D_OFF;
    end else begin
      case (state)
        EWP_D_OFF: begin
          if (cs_rise) begin
            state <= EWP_D_START;
          end
        end
        EWP_D_START: begin
          if (shift_rise && si_s2 == `EWP_START_BIT && !prog_busy) begin
            state <= EWP_D_CMD;
            bit_cnt <= 5'h0;
          end
        end
        EWP_D_CMD: begin
          if (shift_rise) begin
            cmd_sr <= dec[`EWP_CMD_BITS-2:0];
            bit_cnt <= bit_cnt + 5'h1;
            if (bit_cnt == CMD_LAST) begin
              bit_cnt <= 5'h0;
              data_addr <= dec_addr;
              data_all <= dec_op == EWP_OP_EXT;
              case (dec_op)
                EWP_OP_READ: state <= EWP_D_READ;
                EWP_OP_WRITE: state <= EWP_D_DATA;
                EWP_OP_EXT: begin
                  state <= (dec_ext == EWP_EXT_WRITE_ALL) ? EWP_D_DATA : EWP_D_HOLD;
                end
                default: state <= EWP_D_HOLD;
              endcase
            end
          end
        end
        EWP_D_DATA: begin
          if (shift_rise) begin
            data_sr <= {data_sr[DATA_W-2:0], si_s2};
            bit_cnt <= bit_cnt + 5'h1;
            if (bit_cnt == DATA_LAST) begin
              state <= EWP_D_HOLD;
            end
          end
        end
        EWP_D_READ: begin
          if (shift_rise) begin
            bit_cnt <= bit_cnt + 5'h1;
            if (bit_cnt == DATA_LAST) begin
              state <= EWP_D_HOLD; // last bit stays on the line
            end
          end
        end
        default: state <= state; // hold: wait for deselect
      endcase
    end
  end

  // programming permission; only a reset (power loss) or disable clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_enabled <= 1'h0;
    end else if (cmd_done && dec_op == EWP_OP_EXT) begin
      if (dec_ext == EWP_EXT_ENABLE) begin
        prog_enabled <= 1'h1;
      end else if (dec_ext == EWP_EXT_DISABLE) begin
        prog_enabled <= 1'h0;
      end
    end
  end

  // self-timed cycle; the array changes once, at the end of the count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_busy <= 1'h0;
      wp_cnt <= '0;
      pend_all <= 1'h0;
      pend_addr <= '0;
      pend_word <= '0;
    end else if (start_prog) begin
      prog_busy <= 1'h1;
      wp_cnt <= CNT_W'(PROG_CYCLES);
      pend_all <= next_all;
      pend_addr <= next_addr;
      pend_word <= next_word;
    end else if (prog_busy) begin
      wp_cnt <= wp_cnt - 1'h1;
      if (commit) begin
        prog_busy <= 1'h0;
      end
    end
  end

  assign commit = prog_busy && wp_cnt == CNT_W'(1);

  // storage, one flop word per address; writes overwrite without erase
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        mem[i] <= `EWP_ERASED_WORD;
      end else if (commit && (pend_all || pend_addr == ADDR_W'(i))) begin
        mem[i] <= pend_word;
      end
    end
  end

  // deselect time, saturating, so a short glitch cannot arm the status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_low_cnt <= 4'h0;
      status_armed <= 1'h0;
    end else if (!cs_s2) begin
      status_armed <= 1'h0;
      if (cs_low_cnt < CS_LOW_MIN) begin
        cs_low_cnt <= cs_low_cnt + 4'h1;
      end
    end else begin
      cs_low_cnt <= 4'h0;
      if (cs_rise && prog_busy && cs_low_cnt >= CS_LOW_MIN) begin
        status_armed <= 1'h1;
      end
    end
  end

  // serial output: read shifter or ready/busy, released when deselected
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.serial_out <= `EWP_IDLE_LINE;
      link.serial_out_oe <= 1'h0;
      read_drive <= 1'h0;
      rd_sr <= '0;
    end else begin
      link.serial_out_oe <= cs_s2 && (read_drive || status_armed);
      if (!cs_s2) begin
        read_drive <= 1'h0;
      end else if (status_armed) begin
        link.serial_out <= prog_busy ? `EWP_BUSY_BIT : `EWP_READY_BIT;
      end else if (cmd_done && dec_op == EWP_OP_READ) begin
        read_drive <= 1'h1;
        rd_sr <= mem[dec_addr];
        link.serial_out <= `EWP_DUMMY_BIT;
      end else if (shift_rise && state == EWP_D_READ) begin
        link.serial_out <= rd_sr[DATA_W-1];
        rd_sr <= {rd_sr[DATA_W-2:0], rd_sr[DATA_W-1]};
      end
    end
  end
endmodule : ewp_device

// file: src/ewp_host.sv
// ewp_host: controller end of the three-wire link. makes the shift clock
// by dividing ref_clk, and hands read words out through a two-entry buffer.
// assumes serial_out_line is asynchronous and idles high.
`timescale 1ns/1ns
`include "ewp_consts.svh"
module ewp_host
  import ewp_pkg::*;
#(
  parameter int ADDR_W = `EWP_ADDR_W,
  parameter int DATA_W = `EWP_DATA_W,
  parameter int SHIFT_HALF = (`EWP_T_SHIFT_HIGH_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  ewp_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ewp_op_t cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data
);
  localparam int CS_CYC = (`EWP_T_CS_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS;
  localparam int FRAME_W = 1 + `EWP_CMD_BITS + DATA_W;
  localparam logic [5:0] CMD_EDGES = 6'(1 + `EWP_CMD_BITS);
  localparam logic [5:0] DATA_EDGES = 6'(DATA_W);
  localparam logic [5:0] READ_EDGES = 6'(DATA_W + 1);
  localparam logic [4:0] HALF = 5'(SHIFT_HALF - 1);
  localparam logic [4:0] GAP = 5'(CS_CYC - 1);
  localparam logic [4:0] SETTLE = 5'(CS_CYC + `EWP_SYNC_LAT);

  if (SHIFT_HALF < `EWP_SYNC_LAT || SHIFT_HALF > 31 || ADDR_W != `EWP_CMD_BITS - 2
      || DATA_W != `EWP_DATA_W) begin : g_chk
    $error("ewp_host: shift clock divider or geometry not supported");
  end

  ewp_host_state_t state;
  logic so_s1, so_s2;
  logic [4:0] tick;
  logic [5:0] edges;
  logic [5:0] last_edge;
  logic [FRAME_W-1:0] frame;
  logic is_read;
  logic need_poll;
  logic [DATA_W-1:0] rx;
  logic push;
  logic take;
  logic buf_ready;
  logic has_data;

  // two flops before the returned line is read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      so_s1 <= `EWP_IDLE_LINE;
      so_s2 <= `EWP_IDLE_LINE;
    end else begin
      so_s1 <= link.serial_out_line;
      so_s2 <= so_s1;
    end
  end

  assign take = cmd_valid && cmd_ready;
  assign has_data = cmd_op == EWP_OP_WRITE
      || (cmd_op == EWP_OP_EXT && ewp_ext_t'(cmd_addr[ADDR_W-1 -: 2]) == EWP_EXT_WRITE_ALL);

  // offered only when idle and the buffer can absorb a read result
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_ready <= 1'h0;
    end else begin
      cmd_ready <= state == EWP_H_IDLE && buf_ready && !take;
    end
  end

  // frame sequencer: data changes on the falling phase, device samples on rise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= EWP_H_IDLE;
      link.chip_select <= 1'h0;
      link.shift_clock <= 1'h0;
      link.serial_in <= 1'h0;
      tick <= 5'h0;
      edges <= 6'h0;
      last_edge <= 6'h0;
      frame <= '0;
      is_read <= 1'h0;
      need_poll <= 1'h0;
      rx <= '0;
      push <= 1'h0;
    end else begin
      push <= 1'h0;
      case (state)
        EWP_H_IDLE: begin
          if (take) begin
            state <= EWP_H_SHIFT;
            link.chip_select <= 1'h1;
            link.serial_in <= `EWP_START_BIT;
            frame <= {`EWP_START_BIT, cmd_op, cmd_addr, cmd_data};
            tick <= 5'h0;
            edges <= 6'h0;
            is_read <= cmd_op == EWP_OP_READ;
            need_poll <= cmd_op == EWP_OP_WRITE || cmd_op == EWP_OP_ERASE
                || (cmd_op == EWP_OP_EXT && cmd_addr[ADDR_W-1] != cmd_addr[ADDR_W-2]);
            // nine edges at least, more for data or read-back
            last_edge <= CMD_EDGES + (has_data ? DATA_EDGES : 6'h0)
                + (cmd_op == EWP_OP_READ ? READ_EDGES : 6'h0);
          end
        end
        EWP_H_SHIFT: begin
          tick <= tick + 5'h1;
          if (tick == HALF) begin
            tick <= 5'h0;
            if (!link.shift_clock) begin
              link.shift_clock <= 1'h1;
              edges <= edges + 6'h1;
              // edges after the dummy bit carry the word, msb first
              if (is_read && edges > CMD_EDGES) begin
                rx <= {rx[DATA_W-2:0], so_s2};
              end
            end else begin
              link.shift_clock <= 1'h0;
              frame <= {frame[FRAME_W-2:0], 1'h0};
              link.serial_in <= frame[FRAME_W-2];
              if (edges == last_edge) begin
                state <= EWP_H_GAP;
                link.chip_select <= 1'h0;
                link.serial_in <= 1'h0;
                push <= is_read;
              end
            end
          end
        end
        EWP_H_GAP: begin
          tick <= tick + 5'h1;
          if (tick == GAP) begin
            tick <= 5'h0;
            if (need_poll) begin
              state <= EWP_H_POLL;
              link.chip_select <= 1'h1;
            end else begin
              state <= EWP_H_IDLE;
            end
          end
        end
        EWP_H_POLL: begin
          // let the status settle through both synchronisers first
          if (tick != SETTLE) begin
            tick <= tick + 5'h1;
          end else if (so_s2 == `EWP_READY_BIT) begin
            state <= EWP_H_GAP;
            link.chip_select <= 1'h0;
            need_poll <= 1'h0;
            tick <= 5'h0;
          end
        end
        default: state <= EWP_H_IDLE;
      endcase
    end
  end

  // a stalled consumer fills this, which then holds back cmd_ready
  ewp_skid #(
    .WIDTH(DATA_W)
  ) u_rd_buf (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(rx),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule : ewp_host

// file: tb/ewp_checker.sv
// ewp_checker: concurrent checks on the three-wire link between both ends.
// assumes host and device run on the same ref_clk and rst as this module.
`timescale 1ns/1ns
module ewp_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chip_select,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_out_line,
  input wire logic prog_busy,
  input wire logic prog_enabled
);
  logic shift_q;
  logic shift_rise;
  logic [4:0] rises;
  logic [8:0] frame;
  logic [8:0] cmd9;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // shift clock is a host flop on ref_clk, so one delayed copy finds its rises
  assign shift_rise = shift_clock & ~shift_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= 1'b0;
    end else begin
      shift_q <= shift_clock;
    end
  end

  // rises within the current frame; saturates so long frames never wrap
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rises <= 5'h00;
    end else if (!chip_select) begin
      rises <= 5'h00;
    end else if (shift_rise && rises != 5'h1f) begin
      rises <= rises + 5'h01;
    end
  end

  // bits seen on serial_in; the first nine are kept as the command
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame <= 9'h000;
      cmd9 <= 9'h000;
    end else if (shift_rise && chip_select) begin
      frame <= {frame[7:0], serial_in};
      if (rises == 5'h08) begin
        cmd9 <= {frame[7:0], serial_in};
      end
    end
  end

  sequence read_decoded;
    shift_rise && chip_select && rises == 5'h08 && frame[7:5] == 3'h6;
  endsequence

  sequence status_asked;
    $rose(chip_select) ##0 prog_busy [*4];
  endsequence

  a_oe_off_deselect:
    assert property (!chip_select [*6] |-> !serial_out_oe)
    else $error("serial output driven while deselected");
  a_start_bit_first:
    assert property (shift_rise && chip_select && rises == 5'h00 |-> serial_in)
    else $error("frame does not open with a one");
  a_data_bits_whole:
    assert property ($fell(chip_select) && rises >= 5'h09
      && (cmd9[7:6] == 2'h1 || cmd9[7:4] == 4'h1) |-> rises >= 5'h19)
    else $error("data frame cut short");
  a_read_dummy_zero:
    assert property (read_decoded |-> ##[2:8] (serial_out_oe && !serial_out_line))
    else $error("no leading zero after read command");
  a_status_when_busy:
    assert property (status_asked |-> ##[0:6] (serial_out_oe && !serial_out))
    else $error("no status shown during programming");
  a_no_late_status:
    assert property ($rose(chip_select) && !prog_busy |-> !serial_out_oe [*8])
    else $error("status shown with no cycle running");
  a_locked_at_reset:
    assert property ($past(rst) |-> !prog_enabled && !prog_busy)
    else $error("not locked after reset");
  a_prog_only_enabled:
    assert property ($rose(prog_busy) |-> prog_enabled)
    else $error("programming started while locked");
  a_unlock_by_cmd:
    assert property ($rose(prog_enabled) |-> cmd9[8:4] == 5'h13)
    else $error("unlocked without enable command");
  a_lock_by_cmd:
    assert property ($fell(prog_enabled) |-> cmd9[8:4] == 5'h10)
    else $error("locked without disable command");
endmodule : ewp_checker

// file: tb/three_wire_serial_eeprom_port_tb_top.sv
// three_wire_serial_eeprom_port_tb_top: host and device joined over one link,
// driven through the host command port and checked by reading words back.
// assumes package, interface and both ends are compiled before this file.
`timescale 1ns/1ns
module three_wire_serial_eeprom_port_tb_top
  import ewp_pkg::*;
;
  localparam int DLY = 5;
  localparam int LIM = 4000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  ewp_op_t cmd_op = EWP_OP_READ;
  logic [5:0] cmd_addr = 6'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic rd_valid;
  logic rd_ready = 1'b1;
  logic [15:0] rd_data;
  logic prog_busy;
  logic prog_enabled;
  int num_errors = 0;
  int total_checks = 0;

  ewp_if link();

  // 20 MHz reference clock
  always #25 ref_clk = ~ref_clk;

  ewp_host u_ewp_host (.ref_clk(ref_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  // short programming cycle keeps the run brief
  ewp_device #(.PROG_CYCLES(40)) u_ewp_device (.ref_clk(ref_clk), .rst(rst), .link(link),
    .prog_busy(prog_busy), .prog_enabled(prog_enabled));
  ewp_checker u_ewp_checker (.ref_clk(ref_clk), .rst(rst), .chip_select(link.chip_select),
    .shift_clock(link.shift_clock), .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .serial_out_line(link.serial_out_line),
    .prog_busy(prog_busy), .prog_enabled(prog_enabled));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // settled value is what the next edge samples, so no race with the flop
  task automatic wait_idle();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < LIM) begin
      @(posedge ref_clk);
      #DLY;
      n++;
    end
    if (n >= LIM) check(16'h0000, 16'h0001);
  endtask : wait_idle

  // request held until the edge that sees cmd_ready high takes it
  task automatic issue(input ewp_op_t op, input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #DLY;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    wait_idle();
    @(posedge ref_clk);
    #DLY;
    cmd_valid = 1'b0;
  endtask : issue

  task automatic get_word(input logic [15:0] exp);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < LIM) begin
      @(posedge ref_clk);
      #DLY;
      n++;
    end
    if (n >= LIM) check(16'h0000, 16'h0001);
    check(rd_data, exp);
    @(posedge ref_clk);
    #DLY;
  endtask : get_word

  task automatic rd_word(input logic [5:0] a, input logic [15:0] exp);
    issue(EWP_OP_READ, a, 16'h0000);
    get_word(exp);
  endtask : rd_word

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // about twenty commands of a few hundred cycles each; far more is a hang
  initial begin
    #(60000 * 50);
    num_errors++;
    wrap_up();
  end

  // main sequence: locked write, programming ops, then lock and a stalled reader
  initial begin
    repeat (16) @(posedge ref_clk);
    #DLY;
    rst = 1'b0;
    check(16'(prog_enabled), 16'h0000);
    issue(EWP_OP_WRITE, 6'h05, 16'h1234);
    rd_word(6'h05, 16'hffff);
    $display("test locked_write done");
    issue(EWP_OP_EXT, 6'h3a, 16'h0000);
    wait_idle();
    check(16'(prog_enabled), 16'h0001);
    issue(EWP_OP_WRITE, 6'h05, 16'ha5c3);
    issue(EWP_OP_WRITE, 6'h3f, 16'h0001);
    issue(EWP_OP_WRITE, 6'h05, 16'h3c5a);
    rd_word(6'h05, 16'h3c5a);
    rd_word(6'h3f, 16'h0001);
    $display("test write_read done");
    issue(EWP_OP_ERASE, 6'h05, 16'h0000);
    rd_word(6'h05, 16'hffff);
    rd_word(6'h3f, 16'h0001);
    $display("test erase done");
    issue(EWP_OP_EXT, 6'h17, 16'h5a5a);
    rd_word(6'h00, 16'h5a5a);
    rd_word(6'h3f, 16'h5a5a);
    issue(EWP_OP_EXT, 6'h2c, 16'h0000);
    rd_word(6'h11, 16'hffff);
    $display("test whole_array done");
    issue(EWP_OP_WRITE, 6'h01, 16'h0f0f);
    issue(EWP_OP_WRITE, 6'h02, 16'hf0f0);
    issue(EWP_OP_EXT, 6'h05, 16'h0000);
    wait_idle();
    check(16'(prog_enabled), 16'h0000);
    issue(EWP_OP_WRITE, 6'h01, 16'h0000);
    // reader stalls: two words fill the buffer and the port must hold off
    rd_ready = 1'b0;
    issue(EWP_OP_READ, 6'h01, 16'h0000);
    issue(EWP_OP_READ, 6'h02, 16'h0000);
    repeat (600) @(posedge ref_clk);
    #DLY;
    check(16'(cmd_ready), 16'h0000);
    check(rd_data, 16'h0f0f);
    rd_ready = 1'b1;
    get_word(16'h0f0f);
    get_word(16'hf0f0);
    check(16'(rd_valid), 16'h0000);
    $display("test lock_and_stall done");
    wrap_up();
  end
endmodule : three_wire_serial_eeprom_port_tb_top
